// ### core/monitor_sel.v
// monitor point and timing-recovery channel selection, apb slave
// assumes line datapaths of eight channels and a reference clock pin
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "monitor_sel_consts.vh"

module monitor_sel #(
	parameter INIT_CYCLES = `INIT_CYCLES
) (
	// apb
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// mode and straps
	input  wire        host_mode,
	input  wire [3:0]  monitor_select_pins,
	input  wire        top_address_pin,
	input  wire        timing_recovery_strap_pin,
	// per channel line signals
	input  wire [7:0]  rx_pos,
	input  wire [7:0]  rx_neg,
	input  wire [7:0]  rx_clk,
	input  wire [7:0]  tx_pos,
	input  wire [7:0]  tx_neg,
	input  wire [7:0]  tx_clk,
	input  wire        ch0_remote_loopback,
	input  wire        ch0_signal_lost,
	input  wire        ref_clk_pin,
	// channel zero outputs
	output reg         recovered_positive_data,
	output reg         recovered_negative_data,
	output reg         recovered_clock,
	output reg         line_driver_out_a,
	output reg         line_driver_out_b,
	output reg  [7:0]  timing_recovery_active,
	output reg         protected_monitor_point,
	output reg         init_busy
);

	// ------------------------------------------------------------
	// local constants
	// ------------------------------------------------------------
	localparam [31:0] INIT_END = INIT_CYCLES;
	localparam [1:0]  REG_NONE = 2'h0;
	localparam [1:0]  REG_MON  = 2'h1;
	localparam [1:0]  REG_TREC = 2'h2;
	localparam [1:0]  REG_STAT = 2'h3;

	// ------------------------------------------------------------
	// control pin synchronisers
	// ------------------------------------------------------------
	// the top address pin is not read: strap mode trusts the board
	// to hold it low, so no decode depends on it
	reg        host_s1_q;
	reg        host_s2_q;
	reg [3:0]  pins_s1_q;
	reg [3:0]  pins_s2_q;
	reg        strap_s1_q;
	reg        strap_s2_q;
	reg        loop_s1_q;
	reg        loop_s2_q;
	reg        lost_s1_q;
	reg        lost_s2_q;
	reg        ref_s1_q;
	reg        ref_s2_q;
	reg        ref_s3_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_s1_q  <= 1'b0;
			host_s2_q  <= 1'b0;
			pins_s1_q  <= 4'h0;
			pins_s2_q  <= 4'h0;
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
			loop_s1_q  <= 1'b0;
			loop_s2_q  <= 1'b0;
			lost_s1_q  <= 1'b0;
			lost_s2_q  <= 1'b0;
			ref_s1_q   <= 1'b0;
			ref_s2_q   <= 1'b0;
			ref_s3_q   <= 1'b0;
		end else begin
			host_s1_q  <= host_mode;
			host_s2_q  <= host_s1_q;
			pins_s1_q  <= monitor_select_pins;
			pins_s2_q  <= pins_s1_q;
			strap_s1_q <= timing_recovery_strap_pin;
			strap_s2_q <= strap_s1_q;
			loop_s1_q  <= ch0_remote_loopback;
			loop_s2_q  <= loop_s1_q;
			lost_s1_q  <= ch0_signal_lost;
			lost_s2_q  <= lost_s1_q;
			ref_s1_q   <= ref_clk_pin;
			ref_s2_q   <= ref_s1_q;
			ref_s3_q   <= ref_s2_q;
		end
	end

	wire       host_s   = host_s2_q;
	wire [3:0] pins_s   = pins_s2_q;
	wire       strap_s  = strap_s2_q;
	wire       loop_s   = loop_s2_q;
	wire       lost_s   = lost_s2_q;
	wire       ref_rise = ref_s2_q & ~ref_s3_q;

	// ------------------------------------------------------------
	// line level synchronisers
	// ------------------------------------------------------------
	// line levels come from framer clocks unrelated to pclk; a level
	// shorter than about one pclk period may be lost on the way
	wire [7:0] rx_pos_s;
	wire [7:0] rx_neg_s;
	wire [7:0] rx_clk_s;
	wire [7:0] tx_pos_s;
	wire [7:0] tx_neg_s;
	wire [7:0] tx_clk_s;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_line_sync
			reg rp1_q;
			reg rp2_q;
			reg rn1_q;
			reg rn2_q;
			reg rc1_q;
			reg rc2_q;
			reg tp1_q;
			reg tp2_q;
			reg tn1_q;
			reg tn2_q;
			reg tc1_q;
			reg tc2_q;

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					rp1_q <= 1'b0;
					rp2_q <= 1'b0;
					rn1_q <= 1'b0;
					rn2_q <= 1'b0;
					rc1_q <= 1'b0;
					rc2_q <= 1'b0;
					tp1_q <= 1'b0;
					tp2_q <= 1'b0;
					tn1_q <= 1'b0;
					tn2_q <= 1'b0;
					tc1_q <= 1'b0;
					tc2_q <= 1'b0;
				end else begin
					rp1_q <= rx_pos[g];
					rp2_q <= rp1_q;
					rn1_q <= rx_neg[g];
					rn2_q <= rn1_q;
					rc1_q <= rx_clk[g];
					rc2_q <= rc1_q;
					tp1_q <= tx_pos[g];
					tp2_q <= tp1_q;
					tn1_q <= tx_neg[g];
					tn2_q <= tn1_q;
					tc1_q <= tx_clk[g];
					tc2_q <= tc1_q;
				end
			end

			assign rx_pos_s[g] = rp2_q;
			assign rx_neg_s[g] = rn2_q;
			assign rx_clk_s[g] = rc2_q;
			assign tx_pos_s[g] = tp2_q;
			assign tx_neg_s[g] = tn2_q;
			assign tx_clk_s[g] = tc2_q;
		end
	endgenerate

	// ------------------------------------------------------------
	// power-up sequence
	// ------------------------------------------------------------
	reg [31:0] init_cnt_q;
	wire       init_done = (init_cnt_q == INIT_END);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			init_cnt_q <= 32'h0000_0000;
		else if (!init_done)
			init_cnt_q <= init_cnt_q + 32'h0000_0001;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg [7:0] mon_sel_q;
	reg [7:0] trec_en_q;

	// the word index is the byte address shifted down by two
	function [1:0] decode;
		input [11:0] a;
		reg   [11:0] idx;
		begin
			idx = {2'b00, a[11:2]};
			if (idx == `OFF_MON_SEL)
				decode = REG_MON;
			else if (idx == `OFF_TREC_EN)
				decode = REG_TREC;
			else if (idx == `OFF_STATUS)
				decode = REG_STAT;
			else
				decode = REG_NONE;
		end
	endfunction

	wire       acc     = psel & penable;
	wire       take    = acc & ~pready;
	wire [1:0] sel_reg = decode(paddr);
	wire       bad     = (sel_reg == REG_NONE) || (paddr[1:0] != 2'b00);
	wire       wr_ok   = take & pwrite & ~bad;

	// one wait state: ready rises at the second edge of the access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (!init_done) begin
			// the bus stalls until the power-up sequence ends
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= take;
			pslverr <= take & bad;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (init_done & psel & ~pready) begin
			case (sel_reg)
			REG_MON:  prdata <= {24'h00_0000, mon_sel_q};
			REG_TREC: prdata <= {24'h00_0000, trec_en_q};
			REG_STAT: prdata <= {24'h00_0000, timing_recovery_active};
			default:  prdata <= 32'h0000_0000;
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mon_sel_q <= `RST_MON_SEL;
		else if (!init_done)
			mon_sel_q <= `RST_MON_SEL;
		else if (wr_ok && sel_reg == REG_MON)
			mon_sel_q <= {4'h0, pwdata[3:0]};
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			trec_en_q <= `RST_TREC_EN;
		else if (!init_done)
			trec_en_q <= `RST_TREC_EN;
		else if (wr_ok && sel_reg == REG_TREC)
			trec_en_q <= pwdata[7:0];
	end

	// ------------------------------------------------------------
	// selection and routing
	// ------------------------------------------------------------
	// picks one channel of the receive or the transmit side
	function pick;
		input [7:0] rx;
		input [7:0] tx;
		input       use_tx;
		input [2:0] c;
		begin
			if (use_tx)
				pick = tx[c];
			else
				pick = rx[c];
		end
	endfunction

	// strap mode trusts the board to hold the top address pin low
	wire [3:0] sel = host_s ? mon_sel_q[3:0] : pins_s;
	wire [2:0] ch  = sel[2:0];
	wire       mon = init_done && (ch != `CH_ZERO);
	wire       txp = sel[`SEL_TX_BIT];

	wire mon_pos = pick(rx_pos_s, tx_pos_s, txp, ch);
	wire mon_neg = pick(rx_neg_s, tx_neg_s, txp, ch);
	wire mon_clk = pick(rx_clk_s, tx_clk_s, txp, ch);

	// the lost-signal clock comes from the reference clock edges
	reg ref_clk_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ref_clk_q <= 1'b0;
		else if (ref_rise)
			ref_clk_q <= ~ref_clk_q;
	end

	wire own_clk = lost_s ? ref_clk_q : rx_clk_s[`CH_ZERO];
	wire own_pos = rx_pos_s[`CH_ZERO];
	wire own_neg = rx_neg_s[`CH_ZERO];

	// ------------------------------------------------------------
	// channel zero outputs
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recovered_positive_data <= 1'b0;
			recovered_negative_data <= 1'b0;
			recovered_clock         <= 1'b0;
			protected_monitor_point <= 1'b0;
			init_busy               <= 1'b1;
		end else begin
			init_busy               <= ~init_done;
			protected_monitor_point <= mon;
			if (mon) begin
				recovered_positive_data <= mon_pos;
				recovered_negative_data <= mon_neg;
				recovered_clock         <= mon_clk;
			end else begin
				recovered_positive_data <= own_pos;
				recovered_negative_data <= own_neg;
				recovered_clock         <= own_clk;
			end
		end
	end

	// in remote loopback the driver repeats the selected monitor channel, or what channel zero receives when ch is zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_driver_out_a <= 1'b0;
			line_driver_out_b <= 1'b0;
		end else if (loop_s) begin
			line_driver_out_a <= mon ? mon_pos : own_pos;
			line_driver_out_b <= mon ? mon_neg : own_neg;
		end else begin
			line_driver_out_a <= tx_pos_s[`CH_ZERO];
			line_driver_out_b <= tx_neg_s[`CH_ZERO];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			timing_recovery_active <= 8'h00;
		else if (!init_done)
			timing_recovery_active <= 8'h00;
		else if (host_s)
			timing_recovery_active <= trec_en_q;
		else
			timing_recovery_active <= {7'h00, strap_s};
	end

endmodule

// ### inc/monitor_sel_consts.vh
// constants for the monitor and timing-recovery select block
// assumes an apb master on pclk and strap pins from the board
`ifndef MONITOR_SEL_CONSTS_VH
`define MONITOR_SEL_CONSTS_VH

// register offsets are word indexes: the bus byte address is four times
// the index, so the odd printed offsets stay reachable as aligned words
`define OFF_MON_SEL      12'h00b
`define OFF_TREC_EN      12'h01e
`define OFF_STATUS       12'h020
`define RST_MON_SEL      8'h00
`define RST_TREC_EN      8'h00
`define SEL_W            4
`define SEL_TX_BIT       3
`define CH_ZERO          3'h0
`define INIT_TIME_MS     30
`define CLK_MHZ          100
`define INIT_CYCLES      (`INIT_TIME_MS * 1000 * `CLK_MHZ)
`define REF_REFRESH      8'h20

`endif

// ### tb/monitor_sel_monitor.sv
// assertions on the monitor select ports
// assumes a short INIT_CYCLES and strap inputs held still
`timescale 1ns/1ps
module monitor_sel_monitor (
	input logic       pclk, presetn, psel, penable, pready, init_busy,
	input logic       host_mode, timing_recovery_strap_pin,
	input logic       ch0_remote_loopback,
	input logic [3:0] monitor_select_pins,
	input logic [7:0] rx_pos, rx_clk, tx_neg, timing_recovery_active,
	input logic       recovered_positive_data, recovered_negative_data,
	input logic       recovered_clock, line_driver_out_a,
	input logic       protected_monitor_point
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn || init_busy);
	wire [2:0] ch = monitor_select_pins[2:0];
	wire rxs = !monitor_select_pins[3] && ch != 3'h0;
	// four quiet cycles cover the two sync stages and the output flop
	sequence st;
		(!host_mode && $stable(monitor_select_pins)
			&& $stable(timing_recovery_strap_pin))[*4];
	endsequence
	property p_rx;
		st ##0 rxs |-> recovered_positive_data == $past(rx_pos[ch], 3);
	endproperty
	a_rx: assert property (p_rx) else $error("rx data wrong");
	property p_clk;
		st ##0 rxs |-> recovered_clock == $past(rx_clk[ch], 3);
	endproperty
	a_clk: assert property (p_clk) else $error("clock wrong");
	property p_tx;
		st ##0 monitor_select_pins[3] && ch != 3'h0
			|-> recovered_negative_data == $past(tx_neg[ch], 3);
	endproperty
	a_tx: assert property (p_tx) else $error("tx data wrong");
	property p_own;
		st ##0 ch == 3'h0 |-> recovered_positive_data == $past(rx_pos[0], 3);
	endproperty
	a_own: assert property (p_own) else $error("own data wrong");
	property p_pmp;
		st |-> protected_monitor_point == (ch != 3'h0);
	endproperty
	a_pmp: assert property (p_pmp) else $error("monitor flag");
	property p_loop;
		st ##0 rxs && ch0_remote_loopback && $past(ch0_remote_loopback, 3)
			|-> line_driver_out_a == $past(rx_pos[ch], 3);
	endproperty
	a_loop: assert property (p_loop) else $error("loopback out");
	property p_trec;
		st |-> timing_recovery_active == {7'h00, timing_recovery_strap_pin};
	endproperty
	a_trec: assert property (p_trec) else $error("strap trec");
	property p_wait;
		$rose(penable) && psel |=> pready;
	endproperty
	a_wait: assert property (p_wait) else $error("no ready");
endmodule
bind monitor_sel monitor_sel_monitor u_mon (.*);

// ### tb/line_partner.sv
// line side partner: framer data and a reference clock
// assumes pclk at 100 MHz
`timescale 1ns/1ps
module line_partner (
	input  logic       pclk,
	output logic [7:0] rx_pos, rx_neg, rx_clk, tx_pos, tx_neg, tx_clk,
	output logic       ref_clk_pin,
	output logic       top_address_pin
);
	logic [15:0] n = 16'h0000;
	always @(posedge pclk) n <= n + 16'h0001;
	// each channel sees another bit of the count, so a wrong pick shows
	assign {rx_pos, rx_neg} = {n[7:0], ~n[8:1]};
	assign {rx_clk, tx_pos} = {n[9:2], n[10:3]};
	assign {tx_neg, tx_clk} = {n[11:4] ^ 8'h5a, n[12:5]};
	// divide by 64 is the nearest power of two to 1.544 MHz from 100 MHz
	assign ref_clk_pin = n[5];
	assign top_address_pin = 1'b0;
endmodule

// ### tb/monitor_sel_tb.sv
// self-checking bench for the monitor select block
// assumes the monitor and line_partner compiled before it
`timescale 1ns/1ps
`include "monitor_sel_consts.vh"
module monitor_sel_tb;
	localparam [11:0] MON = `OFF_MON_SEL << 2;
	localparam [11:0] TRE = `OFF_TREC_EN << 2;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, er, host_mode = 1, ch0_signal_lost = 0;
	logic timing_recovery_strap_pin = 0, ch0_remote_loopback = 0;
	logic [3:0] monitor_select_pins = 4'h0;
	wire [7:0] rx_pos, rx_neg, rx_clk, tx_pos, tx_neg, tx_clk;
	wire ref_clk_pin, top_address_pin;
	logic [7:0] timing_recovery_active;
	logic recovered_positive_data, recovered_negative_data;
	logic recovered_clock, line_driver_out_a, line_driver_out_b;
	logic protected_monitor_point, init_busy;
	int failures = 0, cmp_count = 0, cyc = 0;
	monitor_sel #(.INIT_CYCLES(20)) dut (.*);
	line_partner lp (.*);
	always #5 pclk = ~pclk;
	task chk(input string nm, input [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task bus(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task t_regs;
		bus(0, MON, 0);
		chk("sel reset", rd, `RST_MON_SEL);
		bus(0, TRE, 0);
		chk("trec reset", rd, `RST_TREC_EN);
		bus(1, MON, 32'h0000_000d);
		bus(0, MON, 0);
		chk("sel read", rd, 32'h0000_000d);
		bus(0, 12'h100, 0);
		chk("unmapped err", er, 1);
		$display("test regs done");
	endtask
	task t_host;
		for (int i = 0; i < 16; i++) begin
			bus(1, MON, i);
			repeat (6) @(posedge pclk);
			chk("host pmp", protected_monitor_point, i % 8 != 0);
		end
		bus(1, TRE, 32'h0000_00a5);
		repeat (6) @(posedge pclk);
		chk("host trec", timing_recovery_active, 8'ha5);
		$display("test host done");
	endtask
	task t_strap;
		host_mode <= 0;
		ch0_remote_loopback <= 1;
		for (int i = 0; i < 32; i++) begin
			{timing_recovery_strap_pin, monitor_select_pins} <= i[4:0];
			repeat (8) @(posedge pclk);
			chk("strap pmp", protected_monitor_point, i % 8 != 0);
			chk("strap trec", timing_recovery_active, i / 16);
		end
		$display("test strap done");
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard, well above the few hundred cycles the tests take
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			wrap_up;
		end
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_host;
		t_strap;
		wrap_up;
	end
endmodule
